// ---- include/rzt_pkg.sv ----
// What this block does
// R1: read-only remote result at pointer 10h, resets 00h
// R2: result loaded only by converter, bus reads only
// R3: result keeps reset value until first conversion
// R4: every register counts one degree per LSB
// R5: eight-bit two's complement, zero is all zeros
// R6: remote hysteresis read/write at 12h, resets 5Ch
// R7: remote setpoint read/write at 13h, resets 61h
// R8: overtemp hysteresis read/write at 22h, resets 5Ch
// R9: overtemp setpoint read/write at 23h, resets 61h
// R10: thresholds store and return all eight bits
// R11: after fault queue, exceeding setpoint sets flag
// R12: overtemp status bit reads one while over
// R13: all threshold comparisons are signed
// R14: release only at or below hysteresis value
package rzt_pkg;

  // ----------------------------------------------------------------
  // widths and types
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned TEMP_W  = 8;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;
  localparam int unsigned CNT_W   = 3;

  // one degree per lsb, signed, zero is all zeros
  typedef logic signed [TEMP_W-1:0] rzt_temp_t;

  typedef struct packed {
    logic      valid;
    rzt_temp_t temp;
  } rzt_conv_t;

  typedef struct packed {
    logic             sel;
    logic             write;
    logic [IDX_W-1:0] idx;
  } rzt_aphase_t;

  // ----------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL    = 8'h01;
  localparam logic [IDX_W-1:0] IDX_RESULT  = 8'h10;
  localparam logic [IDX_W-1:0] IDX_HYST    = 8'h12;
  localparam logic [IDX_W-1:0] IDX_SET     = 8'h13;
  localparam logic [IDX_W-1:0] IDX_OT_HYST = 8'h22;
  localparam logic [IDX_W-1:0] IDX_OT_SET  = 8'h23;
  localparam logic [IDX_W-1:0] IDX_ZSTAT   = 8'h30;
  localparam logic [IDX_W-1:0] IDX_ISTAT   = 8'h31;
  localparam logic [IDX_W-1:0] IDX_ICLR    = 8'h32;
  localparam logic [IDX_W-1:0] IDX_IEN     = 8'h33;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam rzt_temp_t RST_RESULT  = 8'h00;
  localparam rzt_temp_t RST_HYST    = 8'h5c;
  localparam rzt_temp_t RST_SET     = 8'h61;
  localparam rzt_temp_t RST_OT_HYST = 8'h5c;
  localparam rzt_temp_t RST_OT_SET  = 8'h61;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W        = 3;
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_FQ_LSB   = 1;
  localparam int unsigned CTRL_FQ_MSB   = 2;
  localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;

  localparam int unsigned ZS_W       = 2;
  localparam int unsigned ZS_EVT_BIT = 0;
  localparam int unsigned ZS_OT_BIT  = 1;

  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_SET_BIT  = 0;
  localparam int unsigned IRQ_OT_BIT   = 1;
  localparam int unsigned IRQ_CONV_BIT = 2;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

  // fault queue depth codes in conversions
  localparam logic [CNT_W-1:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [CNT_W-1:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [CNT_W-1:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [CNT_W-1:0] FQ_DEPTH_3 = 3'h6;

  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;

endpackage

// ---- logic/rzt_cmp.sv ----
module rzt_cmp (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      sample,
  input  wire rzt_pkg::rzt_temp_t        temp,
  input  wire rzt_pkg::rzt_temp_t        setp,
  input  wire rzt_pkg::rzt_temp_t        hyst,
  input  wire logic [rzt_pkg::CNT_W-1:0] depth,
  output logic                           cond_r,
  output logic                           rise_r
);

  logic [rzt_pkg::CNT_W-1:0] cnt_r;
  logic                      disagree;
  logic                      full;

  // signed operands, so negative readings order correctly
  // trip above setpoint, release at or below hysteresis
  assign disagree = cond_r ? (temp <= hyst) : (temp > setp); // [R13] [R14]
  assign full     = (cnt_r + 3'h1) >= depth;

  // ----------------------------------------------------------------
  // fault queue: a run of depth disagreeing conversions flips state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      cond_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (sample) begin
        if (disagree && full) begin // [R11]
          cnt_r  <= '0;
          cond_r <= !cond_r;
          rise_r <= !cond_r;
        end else if (disagree) begin
          cnt_r <= cnt_r + 3'h1;
        end else begin
          // one agreeing conversion breaks the run
          cnt_r <= '0;
        end
      end
    end
  end

endmodule

// ---- logic/rzt_regs.sv ----
module rzt_regs (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [rzt_pkg::DATA_W-1:0]   hwdata,
  input  wire logic                         hready,
  output logic      [rzt_pkg::DATA_W-1:0]   hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire rzt_pkg::rzt_conv_t           conv,
  output logic                              irq,
  output logic                              overtemp_output,
  output logic                              remote_event_flag
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rzt_pkg::rzt_aphase_t              ap_r;
  logic                              accept;
  logic                              wr_en;
  logic [rzt_pkg::IDX_W-1:0]         rd_idx;

  rzt_pkg::rzt_temp_t                result_r;
  rzt_pkg::rzt_temp_t                hyst_r;
  rzt_pkg::rzt_temp_t                set_r;
  rzt_pkg::rzt_temp_t                ot_hyst_r;
  rzt_pkg::rzt_temp_t                ot_set_r;
  logic [rzt_pkg::CTRL_W-1:0]        ctrl_r;
  logic [rzt_pkg::IRQ_W-1:0]         istat_r;
  logic [rzt_pkg::IRQ_W-1:0]         ien_r;
  logic                              evt_r;

  rzt_pkg::rzt_temp_t                hyst_nxt;
  rzt_pkg::rzt_temp_t                set_nxt;
  rzt_pkg::rzt_temp_t                ot_hyst_nxt;
  rzt_pkg::rzt_temp_t                ot_set_nxt;
  logic [rzt_pkg::CTRL_W-1:0]        ctrl_nxt;
  logic [rzt_pkg::IRQ_W-1:0]         ien_nxt;
  logic [rzt_pkg::IRQ_W-1:0]         istat_nxt;
  logic [rzt_pkg::IRQ_W-1:0]         irq_events;
  logic [rzt_pkg::IRQ_W-1:0]         iclr;
  logic                              evt_nxt;
  logic [rzt_pkg::ZS_W-1:0]          zstat;
  logic [rzt_pkg::CNT_W-1:0]         depth;
  logic [rzt_pkg::DATA_W-1:0]        rdata_nxt;

  logic                              set_cond;
  logic                              set_rise;
  logic                              ot_cond;
  logic                              ot_rise;
  logic                              int_mode;
  logic [rzt_pkg::TEMP_W-1:0]        wbyte;

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  // only whole-word single transfers; hsize is not checked
  assign accept = hsel && htrans[rzt_pkg::HTRANS_ACT_BIT] && hready;
  assign rd_idx = haddr[rzt_pkg::IDX_MSB:rzt_pkg::IDX_LSB];
  assign wr_en  = ap_r.sel && ap_r.write;
  assign wbyte  = hwdata[rzt_pkg::TEMP_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
    end else if (hready) begin
      ap_r.sel   <= accept;
      ap_r.write <= hwrite;
      ap_r.idx   <= rd_idx;
    end
  end

  // zero wait states: every access finishes in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // no error source: every index either maps or reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= rzt_pkg::HRESP_OKAY;
    end else begin
      hresp <= rzt_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // threshold next values, written in the data phase
  // ----------------------------------------------------------------
  always_comb begin
    hyst_nxt    = hyst_r;
    set_nxt     = set_r;
    ot_hyst_nxt = ot_hyst_r;
    ot_set_nxt  = ot_set_r;
    ctrl_nxt    = ctrl_r;
    ien_nxt     = ien_r;
    iclr        = '0;
    if (wr_en) begin
      unique case (ap_r.idx)
        rzt_pkg::IDX_HYST:    hyst_nxt    = wbyte; // [R6] [R10]
        rzt_pkg::IDX_SET:     set_nxt     = wbyte; // [R7] [R10]
        rzt_pkg::IDX_OT_HYST: ot_hyst_nxt = wbyte; // [R8] [R10]
        rzt_pkg::IDX_OT_SET:  ot_set_nxt  = wbyte; // [R9] [R10]
        rzt_pkg::IDX_CTRL:    ctrl_nxt    = hwdata[rzt_pkg::CTRL_W-1:0];
        rzt_pkg::IDX_IEN:     ien_nxt     = hwdata[rzt_pkg::IRQ_W-1:0];
        rzt_pkg::IDX_ICLR:    iclr        = hwdata[rzt_pkg::IRQ_W-1:0];
        // result is read-only, writes to it fall here and vanish
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hyst_r    <= rzt_pkg::RST_HYST;    // [R6]
      ot_hyst_r <= rzt_pkg::RST_OT_HYST; // [R8]
    end else begin
      hyst_r    <= hyst_nxt;
      ot_hyst_r <= ot_hyst_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_r     <= rzt_pkg::RST_SET;     // [R7]
      ot_set_r  <= rzt_pkg::RST_OT_SET;  // [R9]
    end else begin
      set_r     <= set_nxt;
      ot_set_r  <= ot_set_nxt;
    end
  end

  // mode and queue depth act from the edge after the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= rzt_pkg::RST_CTRL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_r <= rzt_pkg::RST_IRQ;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  // ----------------------------------------------------------------
  // remote result, loaded by the converter alone
  // ----------------------------------------------------------------
  // until the first conversion it still holds its reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= rzt_pkg::RST_RESULT; // [R1] [R3]
    end else if (conv.valid) begin
      result_r <= conv.temp; // [R2] [R4] [R5]
    end
  end

  // ----------------------------------------------------------------
  // fault queue depth and comparators
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl_r[rzt_pkg::CTRL_FQ_MSB:rzt_pkg::CTRL_FQ_LSB])
      2'h0: depth = rzt_pkg::FQ_DEPTH_0;
      2'h1: depth = rzt_pkg::FQ_DEPTH_1;
      2'h2: depth = rzt_pkg::FQ_DEPTH_2;
      2'h3: depth = rzt_pkg::FQ_DEPTH_3;
    endcase
  end

  // compare the fresh sample, not the stored result, to save a cycle
  rzt_cmp u_set_cmp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sample  (conv.valid),
    .temp    (conv.temp),
    .setp    (set_r),
    .hyst    (hyst_r),
    .depth   (depth),
    .cond_r  (set_cond),
    .rise_r  (set_rise)
  );

  rzt_cmp u_ot_cmp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sample  (conv.valid),
    .temp    (conv.temp),
    .setp    (ot_set_r),
    .hyst    (ot_hyst_r),
    .depth   (depth),
    .cond_r  (ot_cond),
    .rise_r  (ot_rise)
  );

  assign overtemp_output = ot_cond; // [R12]

  // ----------------------------------------------------------------
  // remote event flag
  // ----------------------------------------------------------------
  // comparator mode: follows the setpoint state; interrupt mode:
  // sticky, cleared by reading zone status, a new trip wins the clear
  assign int_mode = ctrl_r[rzt_pkg::CTRL_MODE_BIT];

  always_comb begin
    evt_nxt = evt_r;
    if (!int_mode) begin
      evt_nxt = set_cond;
    end else begin
      if (accept && !hwrite && (rd_idx == rzt_pkg::IDX_ZSTAT)) begin
        evt_nxt = 1'b0;
      end
      if (set_rise || ot_rise) begin
        evt_nxt = 1'b1; // [R11]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign remote_event_flag = evt_r;

  always_comb begin
    zstat                       = '0;
    zstat[rzt_pkg::ZS_EVT_BIT]  = evt_r;
    zstat[rzt_pkg::ZS_OT_BIT]   = ot_cond; // [R12]
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------
  always_comb begin
    irq_events                        = '0;
    irq_events[rzt_pkg::IRQ_SET_BIT]  = set_rise;
    irq_events[rzt_pkg::IRQ_OT_BIT]   = ot_rise;
    irq_events[rzt_pkg::IRQ_CONV_BIT] = conv.valid;
    // an event in the clearing cycle survives the clear
    istat_nxt = (istat_r & ~iclr) | irq_events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= rzt_pkg::RST_IRQ;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  // registered, so it trails the status bit by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_r & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // next values are muxed so a read right after a write sees it
  always_comb begin
    rdata_nxt = '0;
    unique case (rd_idx)
      rzt_pkg::IDX_RESULT:  rdata_nxt[rzt_pkg::TEMP_W-1:0] = result_r; // [R1]
      rzt_pkg::IDX_HYST:    rdata_nxt[rzt_pkg::TEMP_W-1:0] = hyst_nxt; // [R10]
      rzt_pkg::IDX_SET:     rdata_nxt[rzt_pkg::TEMP_W-1:0] = set_nxt;
      rzt_pkg::IDX_OT_HYST: rdata_nxt[rzt_pkg::TEMP_W-1:0] = ot_hyst_nxt;
      rzt_pkg::IDX_OT_SET:  rdata_nxt[rzt_pkg::TEMP_W-1:0] = ot_set_nxt;
      rzt_pkg::IDX_CTRL:    rdata_nxt[rzt_pkg::CTRL_W-1:0] = ctrl_nxt;
      rzt_pkg::IDX_ZSTAT:   rdata_nxt[rzt_pkg::ZS_W-1:0]   = zstat;
      rzt_pkg::IDX_ISTAT:   rdata_nxt[rzt_pkg::IRQ_W-1:0]  = istat_r;
      rzt_pkg::IDX_IEN:     rdata_nxt[rzt_pkg::IRQ_W-1:0]  = ien_nxt;
      // clear register and unmapped indexes read as zero
      default: begin
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (accept && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

endmodule

// ---- verif/rzt_regs_monitor.sv ----
module rzt_regs_monitor (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire rzt_pkg::rzt_conv_t conv,
  input wire logic               irq,
  input wire logic               overtemp_output,
  input wire logic               remote_event_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // shadow of the writable registers
  // ----------------------------------------
  logic               wr_r;
  logic [7:0]         idx_r;
  logic [2:0]         ctrl_r;
  logic [2:0]         ien_r;
  rzt_pkg::rzt_temp_t hy_r, st_r, oh_r, os_r, res_r, t;
  logic               rd_take;
  logic               fq1;
  assign t = conv.temp;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // depth one only: longer queues are judged by the bench
  assign fq1 = ctrl_r[2:1] == 2'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r  <= 1'h0;
      idx_r <= 8'h00;
    end else if (hready) begin
      wr_r  <= hsel && htrans[1] && hwrite;
      idx_r <= haddr[9:2];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 3'h0;
      ien_r  <= 3'h0;
      hy_r   <= 8'h5c;
      st_r   <= 8'h61;
      oh_r   <= 8'h5c;
      os_r   <= 8'h61;
    end else if (wr_r && hready) begin
      case (idx_r)
        8'h01: ctrl_r <= hwdata[2:0];
        8'h12: hy_r <= hwdata[7:0];
        8'h13: st_r <= hwdata[7:0];
        8'h22: oh_r <= hwdata[7:0];
        8'h23: os_r <= hwdata[7:0];
        8'h33: ien_r <= hwdata[2:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      res_r <= 8'h00;
    else if (conv.valid)
      res_r <= t;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_RESULT_RD: assert property (rd_take && haddr[9:2] == 8'h10 && !conv.valid |=> hrdata == {24'h0, res_r})
    else $error("result read differs from last conversion");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_OT_RISE: assert property (conv.valid && fq1 && t > os_r && t > oh_r |=> overtemp_output)
    else $error("overtemp not raised");
  AST_OT_HOLD: assert property (overtemp_output && conv.valid && t > oh_r |=> overtemp_output)
    else $error("overtemp released above hysteresis");
  AST_OT_FALL: assert property (conv.valid && fq1 && t <= oh_r && t <= os_r |=> !overtemp_output)
    else $error("overtemp not released");
  AST_OT_STEADY: assert property (!conv.valid |=> $stable(overtemp_output))
    else $error("overtemp moved without a conversion");
  AST_EVT_CMP: assert property (conv.valid && fq1 && !ctrl_r[0] && t > st_r && t > hy_r |=> ##[0:1] remote_event_flag)
    else $error("event flag not raised");
  AST_IRQ_CONV: assert property (conv.valid && ien_r[2] |-> ##[1:3] irq)
    else $error("conversion done interrupt missing");
  AST_IRQ_MASK: assert property (ien_r == 3'h0 && $past(ien_r) == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
  cover property (conv.valid && t > os_r);
  cover property ($rose(irq));
  cover property ($fell(overtemp_output));
endmodule

// ---- verif/rzt_conv_model.sv ----
module rzt_conv_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               start,
  input  wire logic [7:0]         lat,
  input  wire rzt_pkg::rzt_temp_t temp_in,
  output rzt_pkg::rzt_conv_t      conv,
  output logic                    busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]         cnt_r;
  logic               vld_r;
  rzt_pkg::rzt_temp_t val_r;
  // idle data lines show the inverse, so a stray sample cannot match by luck
  assign conv = {vld_r, vld_r ? val_r : ~val_r};
  assign busy = start || cnt_r != 8'h00 || vld_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
      vld_r <= 1'h0;
      val_r <= 8'h00;
    end else begin
      vld_r <= cnt_r == 8'h01;
      if (start) begin
        cnt_r <= lat + 8'h01;
        val_r <= temp_in;
      end else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// ---- verif/tb_rzt_regs.sv ----
module tb_rzt_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic               hclk, hresetn, hsel, hwrite, start, busy;
  logic               hready, hreadyout, hresp, irq, ot, evt;
  logic [31:0]        haddr, hwdata, hrdata, d;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [7:0]         lat;
  rzt_pkg::rzt_temp_t temp_in;
  rzt_pkg::rzt_conv_t conv;
  int                 err_total, n_compared, cyc;
  logic [7:0]         idx_t[5] = '{8'h10, 8'h12, 8'h13, 8'h22, 8'h23};
  logic [7:0]         rst_t[5] = '{8'h00, 8'h5c, 8'h61, 8'h5c, 8'h61};
  assign hready = hreadyout;
  rzt_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv(conv), .irq(irq), .overtemp_output(ot),
    .remote_event_flag(evt));
  rzt_conv_model i_conv (.hclk(hclk), .hresetn(hresetn), .start(start), .lat(lat),
    .temp_in(temp_in), .conv(conv), .busy(busy));
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // bus and converter drivers
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsel   <= 1'h1;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'h0, idx, 32'h0);
    chk(d, exp);
    chk({30'h0, hready, hresp}, 32'h2);
  endtask
  task automatic convert(input rzt_pkg::rzt_temp_t t, input logic [7:0] l);
    temp_in <= t;
    lat     <= l;
    start   <= 1'h1;
    @(posedge hclk);
    start   <= 1'h0;
    @(posedge hclk);
    while (busy) @(posedge hclk);
    repeat (3) @(posedge hclk);
  endtask
  // comparator mode only: a zone status read leaves the level flag alone
  task automatic state_chk(input logic [1:0] e);
    chk({30'h0, ot, evt}, {30'h0, e});
    rdchk(8'h30, {30'h0, e});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rdchk(idx_t[i], {24'h0, rst_t[i]});
    end
    chk({29'h0, irq, ot, evt}, 32'h0);
  endtask
  task automatic t_rw();
    for (int i = 1; i < 5; i++) begin
      xfer(1'h1, idx_t[i], 32'hffff_ffa5);
      rdchk(idx_t[i], 32'h0000_00a5);
      xfer(1'h1, idx_t[i], 32'h0000_005a);
      rdchk(idx_t[i], 32'h0000_005a);
    end
    xfer(1'h1, 8'h10, 32'h0000_0077);
    rdchk(8'h10, 32'h0);
    rdchk(8'h3f, 32'h0);
  endtask
  task automatic t_result();
    convert(8'he7, 8'h00);
    rdchk(8'h10, 32'h0000_00e7);
    convert(8'h7f, 8'h07);
    rdchk(8'h10, 32'h0000_007f);
  endtask
  task automatic t_cmp();
    logic [7:0] thr[4] = '{8'h02, 8'h05, 8'h08, 8'h0a};
    logic [7:0] tv[7] = '{8'h80, 8'h06, 8'h0b, 8'h09, 8'h08, 8'h03, 8'h02};
    logic [1:0] ev[7] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0};
    for (int i = 1; i < 5; i++) xfer(1'h1, idx_t[i], {24'h0, thr[i-1]});
    for (int i = 0; i < 7; i++) begin
      convert(tv[i], 8'h00);
      state_chk(ev[i]);
    end
  endtask
  task automatic t_fq();
    xfer(1'h1, 8'h01, 32'h2);
    convert(8'h20, 8'h00);
    state_chk(2'h0);
    convert(8'h20, 8'h03);
    state_chk(2'h3);
    xfer(1'h1, 8'h01, 32'h4);
    repeat (3) convert(8'h00, 8'h00);
    state_chk(2'h3);
    convert(8'h00, 8'h00);
    state_chk(2'h0);
    xfer(1'h1, 8'h01, 32'h6);
    repeat (5) convert(8'h20, 8'h00);
    state_chk(2'h0);
    convert(8'h20, 8'h00);
    state_chk(2'h3);
    xfer(1'h1, 8'h01, 32'h0);
    convert(8'h00, 8'h00);
    state_chk(2'h0);
  endtask
  task automatic t_irq();
    xfer(1'h1, 8'h32, 32'h7);
    xfer(1'h1, 8'h33, 32'h0);
    convert(8'h20, 8'h00);
    rdchk(8'h31, 32'h7);
    chk({31'h0, irq}, 32'h0);
    xfer(1'h1, 8'h33, 32'h4);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'h1, 8'h32, 32'h4);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(8'h31, 32'h3);
    xfer(1'h1, 8'h01, 32'h1);
    convert(8'h00, 8'h00);
    xfer(1'h0, 8'h30, 32'h0);
    convert(8'h20, 8'h00);
    convert(8'h00, 8'h00);
    chk({31'h0, evt}, 32'h1);
    rdchk(8'h30, 32'h1);
    @(posedge hclk);
    chk({31'h0, evt}, 32'h0);
  endtask
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    start = 1'h0;
    lat = 8'h00;
    temp_in = 8'h00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_rw();
    t_result();
    t_cmp();
    t_fq();
    t_irq();
    report_and_stop();
  end
endmodule
bind rzt_regs rzt_regs_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .conv(conv),
  .irq(irq), .overtemp_output(overtemp_output), .remote_event_flag(remote_event_flag));
